// [common/mmio_consts.svh]
// Constants for the maskable multi-set I/O port.
// Included by the package and design files; definitions only.
`ifndef MMIO_CONSTS_SVH
`define MMIO_CONSTS_SVH

`define MMIO_PINS        40
`define MMIO_SETS        8
`define MMIO_SET_W       3
`define MMIO_FN_W        10
`define MMIO_LO_W        32
`define MMIO_HI_W        8
`define MMIO_HI_LSB      32
`define MMIO_FN_STD_IO   10'h001
`define MMIO_FN_MASK_IO  10'h002
`define MMIO_MASK_RST    40'hFF_FFFF_FFFF
`define MMIO_DIR_RST     40'h00_0000_0000
`define MMIO_LVL_RST     40'h00_0000_0000
`define MMIO_SEL_MASK    2'h0
`define MMIO_SEL_DIR     2'h1
`define MMIO_SEL_LVL     2'h2
`define MMIO_SEL_STS     2'h3

`endif

// [common/mmio_pkg.sv]
// Types shared by the maskable multi-set I/O port modules.
// Assumes mmio_consts.svh is on the include path.
`default_nettype none
`include "mmio_consts.svh"

package mmio_pkg;
    typedef logic [`MMIO_PINS-1:0] mmio_pins_t;
    typedef logic [`MMIO_FN_W-1:0] mmio_fn_t;
    typedef enum logic [1:0]
    {
        MMIO_FIELD_MASK,
        MMIO_FIELD_DIR,
        MMIO_FIELD_LVL,
        MMIO_FIELD_STS
    } mmio_field_t;
endpackage

`default_nettype wire

// [common/mmio_pin_if.sv]
// Carries per-pin drive state from the control core to the pad stage.
// Both ends share the port clock.
`timescale 1ns/1ps
`default_nettype none

interface mmio_pin_if;
    mmio_pkg::mmio_pins_t drive;
    mmio_pkg::mmio_pins_t level;
    mmio_pkg::mmio_pins_t owned;
    mmio_pkg::mmio_pins_t sampled;
    modport core (output drive, output level, output owned,
                  input sampled);
    modport pad  (input drive, input level, input owned,
                  output sampled);
endinterface

`default_nettype wire

// [hw/mmio_pad_stage.sv]
// Pad stage: output drivers and registered level readback with keeper.
// Assumes pin inputs are synchronous to CLOCK_I.
`timescale 1ns/1ps
`default_nettype none
`include "mmio_consts.svh"

module mmio_pad_stage
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    mmio_pin_if.pad                   pins,
    input  wire mmio_pkg::mmio_pins_t keep_en_i,
    input  wire mmio_pkg::mmio_pins_t pin_in_i,
    output logic [`MMIO_PINS-1:0]     pin_out_o,
    output logic [`MMIO_PINS-1:0]     pin_oe_o
);
    mmio_pkg::mmio_pins_t level_reg;
    mmio_pkg::mmio_pins_t level_next;
    wire mmio_pkg::mmio_pins_t oe_w = pins.drive & pins.owned;

    // A driven pin reads back its own level; undriven with keeper holds
    assign level_next = (oe_w & pins.level)
                      | (~oe_w & keep_en_i & level_reg)
                      | (~oe_w & ~keep_en_i & pin_in_i);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            level_reg <= `MMIO_LVL_RST;
            pin_out_o <= `MMIO_LVL_RST;
            pin_oe_o  <= `MMIO_DIR_RST;
        end
        else
        begin
            level_reg <= level_next;
            pin_out_o <= pins.level;
            pin_oe_o  <= oe_w;
        end
    end

    assign pins.sampled = level_reg;
endmodule

`default_nettype wire

// [hw/mmio_port.sv]
// Maskable multi-set I/O port: eight control sets over forty pins.
// Assumes a plain-port write/read strobe from the register side and pins
// that are synchronous to CLOCK_I; the pad ring does the actual tristate.
`timescale 1ns/1ps
`default_nettype none
`include "mmio_consts.svh"

module mmio_port
(
    input  wire logic                                CLOCK_I,
    input  wire logic                                RST_I,
    input  wire logic                                WR_EN_I,
    input  wire logic [`MMIO_SET_W-1:0]              WR_SET_I,
    input  wire logic [1:0]                          WR_FIELD_I,
    input  wire logic                                WR_HI_I,
    input  wire logic [`MMIO_LO_W-1:0]               WR_DATA_I,
    input  wire logic [`MMIO_SET_W-1:0]              RD_SET_I,
    input  wire logic [1:0]                          RD_FIELD_I,
    input  wire logic                                RD_HI_I,
    output logic      [`MMIO_LO_W-1:0]               RD_DATA_O,
    input  wire logic [`MMIO_PINS*`MMIO_FN_W-1:0]    PIN_FN_I,
    input  wire logic [`MMIO_PINS-1:0]               KEEP_EN_I,
    input  wire logic [`MMIO_PINS-1:0]               PIN_IN_I,
    output logic      [`MMIO_PINS-1:0]               PIN_OUT_O,
    output logic      [`MMIO_PINS-1:0]               PIN_OE_O,
    output logic      [`MMIO_PINS-1:0]               PIN_LEVEL_O
);
    mmio_pin_if pin_bus ();

    mmio_pkg::mmio_pins_t mask_reg [`MMIO_SETS];
    mmio_pkg::mmio_pins_t dir_reg  [`MMIO_SETS];
    mmio_pkg::mmio_pins_t lvl_reg  [`MMIO_SETS];
    mmio_pkg::mmio_pins_t drive_reg;
    mmio_pkg::mmio_pins_t drive_next;
    mmio_pkg::mmio_pins_t out_reg;
    mmio_pkg::mmio_pins_t out_next;
    mmio_pkg::mmio_pins_t sts_reg;
    logic [`MMIO_LO_W-1:0] rd_next;

    // Spread one written word over the forty pin positions
    function automatic mmio_pkg::mmio_pins_t widen
    (
        input logic [`MMIO_LO_W-1:0] data,
        input logic                  hi
    );
        widen = hi ? {data[`MMIO_HI_W-1:0], `MMIO_LO_W'h0}
                   : {`MMIO_HI_W'h0, data};
    endfunction

    // Select the word of a pin vector seen by a read
    function automatic logic [`MMIO_LO_W-1:0] narrow
    (
        input mmio_pkg::mmio_pins_t v,
        input logic                 hi
    );
        narrow = hi ? {{(`MMIO_LO_W-`MMIO_HI_W){1'b0}},
                       v[`MMIO_PINS-1:`MMIO_HI_LSB]}
                    : v[`MMIO_LO_W-1:0];
    endfunction

    // Replace only the bits flagged in keep-clear positions
    function automatic mmio_pkg::mmio_pins_t merge
    (
        input mmio_pkg::mmio_pins_t old_v,
        input mmio_pkg::mmio_pins_t new_v,
        input mmio_pkg::mmio_pins_t upd
    );
        merge = (old_v & ~upd) | (new_v & upd);
    endfunction

    wire mmio_pkg::mmio_pins_t wr_word  = widen(WR_DATA_I, WR_HI_I);
    wire mmio_pkg::mmio_pins_t wr_range = widen({`MMIO_LO_W{1'b1}},
                                                WR_HI_I);
    wire mmio_pkg::mmio_pins_t wr_mask  = mask_reg[WR_SET_I];
    // Writable pins: in the addressed word and unmasked in this set
    wire mmio_pkg::mmio_pins_t wr_open  = wr_range & ~wr_mask;
    wire wr_mask_w = WR_EN_I && (WR_FIELD_I == `MMIO_SEL_MASK);
    wire wr_dir_w  = WR_EN_I && (WR_FIELD_I == `MMIO_SEL_DIR);
    wire wr_lvl_w  = WR_EN_I && (WR_FIELD_I == `MMIO_SEL_LVL);

    // Per-pin ownership by function select
    mmio_pkg::mmio_pins_t owned_w;
    mmio_pkg::mmio_pins_t std_in_w;
    genvar g;
    generate
        for (g = 0; g < `MMIO_PINS; g++)
        begin : g_fn
            wire mmio_pkg::mmio_fn_t fn_w =
                PIN_FN_I[g*`MMIO_FN_W +: `MMIO_FN_W];
            assign owned_w[g]  = (fn_w == `MMIO_FN_MASK_IO);
            assign std_in_w[g] = (fn_w == `MMIO_FN_STD_IO);
        end
    endgenerate

    // Drive latches on an unmasked output write and only clears on an
    // unmasked input write or a function change; mask alone never drops it
    assign drive_next = owned_w
        & (wr_dir_w ? merge(drive_reg, wr_word, wr_open)
                    : drive_reg);
    assign out_next = wr_lvl_w ? merge(out_reg, wr_word, wr_open)
                               : out_reg;

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            for (int s = 0; s < `MMIO_SETS; s++)
            begin
                mask_reg[s] <= `MMIO_MASK_RST;
                dir_reg[s]  <= `MMIO_DIR_RST;
                lvl_reg[s]  <= `MMIO_LVL_RST;
            end
            drive_reg <= `MMIO_DIR_RST;
            out_reg   <= `MMIO_LVL_RST;
            sts_reg   <= `MMIO_LVL_RST;
            RD_DATA_O <= `MMIO_LO_W'h0;
        end
        else
        begin
            if (wr_mask_w)
                mask_reg[WR_SET_I] <= merge(wr_mask, wr_word, wr_range);
            if (wr_dir_w)
                dir_reg[WR_SET_I] <= merge(dir_reg[WR_SET_I], wr_word,
                                           wr_open);
            if (wr_lvl_w)
                lvl_reg[WR_SET_I] <= merge(lvl_reg[WR_SET_I], wr_word,
                                           wr_open);
            drive_reg <= drive_next;
            out_reg   <= out_next;
            // Status only for port pins and standard inputs
            sts_reg   <= pin_bus.sampled & (owned_w | std_in_w);
            RD_DATA_O <= rd_next;
        end
    end

    // Level field reads the stored control value, not the pin
    always_comb
    begin
        case (RD_FIELD_I)
            `MMIO_SEL_MASK: rd_next = narrow(mask_reg[RD_SET_I], RD_HI_I);
            `MMIO_SEL_DIR:  rd_next = narrow(dir_reg[RD_SET_I], RD_HI_I);
            `MMIO_SEL_LVL:  rd_next = narrow(lvl_reg[RD_SET_I], RD_HI_I);
            `MMIO_SEL_STS:  rd_next = narrow(sts_reg, RD_HI_I);
            default:        rd_next = `MMIO_LO_W'h0;
        endcase
    end

    assign pin_bus.drive = drive_reg;
    assign pin_bus.level = out_reg;
    assign pin_bus.owned = owned_w;
    assign PIN_LEVEL_O   = sts_reg;

    mmio_pad_stage u_pad
    (
        .clk_i     (CLOCK_I),
        .rst_i     (RST_I),
        .pins      (pin_bus),
        .keep_en_i (KEEP_EN_I),
        .pin_in_i  (PIN_IN_I),
        .pin_out_o (PIN_OUT_O),
        .pin_oe_o  (PIN_OE_O)
    );
endmodule

`default_nettype wire

// [verif/mmio_port_monitor.sv]
// Checker on the top ports of the maskable I/O port.
// Assumes pins and function selects are synchronous to CLOCK_I.
`timescale 1ns/1ps
`default_nettype none
`include "mmio_consts.svh"
module mmio_port_monitor
(
    input wire logic         CLOCK_I,
    input wire logic         RST_I,
    input wire logic         WR_EN_I,
    input wire logic [1:0]   WR_FIELD_I,
    input wire logic [1:0]   RD_FIELD_I,
    input wire logic         RD_HI_I,
    input wire logic [31:0]  RD_DATA_O,
    input wire logic [399:0] PIN_FN_I,
    input wire logic [39:0]  PIN_OUT_O,
    input wire logic [39:0]  PIN_OE_O,
    input wire logic [39:0]  PIN_LEVEL_O
);
    logic [39:0] fm;
    logic [39:0] fs;
    always_comb
        for (int k = 0; k < 40; k++)
        begin
            fm[k] = PIN_FN_I[10*k +: 10] == `MMIO_FN_MASK_IO;
            fs[k] = fm[k] || PIN_FN_I[10*k +: 10] == `MMIO_FN_STD_IO;
        end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    a_oe_in_port: assert property
        ((PIN_OE_O & ~$past(fm)) == 40'h0) else $error("drive off port");
    a_stat_zero: assert property
        ((PIN_LEVEL_O & ~$past(fs)) == 40'h0)
        else $error("status off port");
    a_drv_level: assert property
        (((PIN_LEVEL_O ^ $past(PIN_OUT_O)) & $past(PIN_OE_O) & $past(fm)
        & $past(fm, 2)) == 40'h0) else $error("driven readback");
    a_hi_zero: assert property
        ($past(RD_HI_I) |-> RD_DATA_O[31:8] == 24'h0) else $error("hi word");
    a_sts_read: assert property
        ($past(RD_FIELD_I) == `MMIO_SEL_STS |-> RD_DATA_O == ($past(RD_HI_I)
        ? {24'h0, $past(PIN_LEVEL_O[39:32])} : $past(PIN_LEVEL_O[31:0])))
        else $error("status read");
    a_oe_rise: assert property
        ((PIN_OE_O & ~$past(PIN_OE_O)) != 40'h0 |-> $past(WR_EN_I, 2)
        && $past(WR_FIELD_I, 2) == `MMIO_SEL_DIR) else $error("oe rise");
    a_oe_cause: assert property
        ($changed(PIN_OE_O) |-> ($past(WR_EN_I, 2) && $past(WR_FIELD_I, 2)
        == `MMIO_SEL_DIR) || $past(PIN_FN_I) != $past(PIN_FN_I, 3))
        else $error("oe change");
    a_out_cause: assert property
        ($changed(PIN_OUT_O) |-> $past(WR_EN_I, 2) && $past(WR_FIELD_I, 2)
        == `MMIO_SEL_LVL) else $error("out change");
endmodule
bind mmio_port mmio_port_monitor u_mon (.CLOCK_I, .RST_I, .WR_EN_I,
    .WR_FIELD_I, .RD_FIELD_I, .RD_HI_I, .RD_DATA_O, .PIN_FN_I, .PIN_OUT_O,
    .PIN_OE_O, .PIN_LEVEL_O);
`default_nettype wire

// [verif/mmio_pin_model.sv]
// Board around the port pins: drives chosen lines, others float.
// Where the bench and the port both drive a line, the port's level wins.
`timescale 1ns/1ps
`default_nettype none
module mmio_pin_model
(
    input  wire logic        clk_i,
    input  wire logic [39:0] out_i,
    input  wire logic [39:0] oe_i,
    input  wire logic [39:0] ext_en_i,
    input  wire logic [39:0] ext_val_i,
    output logic      [39:0] pin_o
);
    logic [39:0] flt_reg = 40'h0;
    // Floating lines toggle so a stale level never passes for a hold
    always_ff @(posedge clk_i)
        flt_reg <= ~flt_reg;
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~oe_i & ~ext_en_i & flt_reg);
endmodule
`default_nettype wire

// [verif/mmio_port_tb_top.sv]
// Bench: random set writes and reads checked against a model.
// Assumes the pin model stands for the board around the port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module mmio_port_tb_top;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         we = 1'b0;
    logic         wh = 1'b0;
    logic         rh = 1'b0;
    logic [2:0]   ws = 3'h0;
    logic [2:0]   rs = 3'h0;
    logic [1:0]   wf = 2'h0;
    logic [1:0]   rf = 2'h0;
    logic [31:0]  wd = 32'h0;
    logic [399:0] fn = {40{10'h002}};
    logic [39:0]  keep = 40'h0;
    logic [39:0]  ee = 40'h0;
    logic [39:0]  ev = 40'h0;
    logic [39:0]  pin, pout, poe, plev, fm, fs, drv, olv, p1;
    logic [39:0]  m [3][8];
    logic [31:0]  rd;
    int           errors = 0;
    int           n_checks = 0;
    always #10 clk = ~clk;
    always_comb
        for (int k = 0; k < 40; k++)
        begin
            fm[k] = fn[10*k +: 10] == 10'h002;
            fs[k] = fm[k] || fn[10*k +: 10] == 10'h001;
        end
    mmio_port u_dut (.CLOCK_I(clk), .RST_I(rst), .WR_EN_I(we), .WR_SET_I(ws),
        .WR_FIELD_I(wf), .WR_HI_I(wh), .WR_DATA_I(wd), .RD_SET_I(rs),
        .RD_FIELD_I(rf), .RD_HI_I(rh), .RD_DATA_O(rd), .PIN_FN_I(fn),
        .KEEP_EN_I(keep), .PIN_IN_I(pin), .PIN_OUT_O(pout), .PIN_OE_O(poe),
        .PIN_LEVEL_O(plev));
    mmio_pin_model u_pins (.clk_i(clk), .out_i(pout), .oe_i(poe),
        .ext_en_i(ee), .ext_val_i(ev), .pin_o(pin));
    task automatic wr(input int s, f, h, input logic [31:0] d);
        logic [39:0] w, v, u, tk;
        w = h ? 40'hFF_0000_0000 : 40'h00_FFFF_FFFF;
        v = h ? {d[7:0], 32'h0} : {8'h0, d};
        tk = 40'h0;
        for (int j = 0; j < 8; j++)
            if (j != s)
                tk |= ~m[0][j];
        u = w & ~m[0][s];
        // Never unmask a pin already held by another set
        if (f == 0)
            v |= tk;
        if (f == 0)
            m[0][s] = (m[0][s] & ~w) | (v & w);
        else if (f < 3)
            m[f][s] = (m[f][s] & ~u) | (v & u);
        if (f == 1)
            drv = (drv & ~u) | (v & u);
        if (f == 2)
            olv = (olv & ~u) | (v & u);
        @(posedge clk);
        we <= 1'b1; ws <= 3'(s); wf <= 2'(f); wh <= h[0];
        wd <= h ? {24'h0, v[39:32]} : v[31:0];
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic chk;
        logic [39:0] e;
        int s, f, h;
        s = $urandom % 8; f = $urandom % 4; h = $urandom % 2;
        repeat (4) @(posedge clk);
        drv &= fm;
        rs <= 3'(s); rf <= 2'(f); rh <= h[0];
        #1 p1 = plev;
        e = (f == 3) ? p1 : m[f][s];
        `CHK(poe, drv & fm)
        `CHK(pout, olv)
        `CHK(plev & poe, olv & poe)
        `CHK(plev & ~fs, 40'h0)
        // A floating line toggles every rising edge, so two edges late equals now
        `CHK(plev & ~poe & fs & ~ee, pin & ~poe & fs & ~ee)
        `CHK(plev & ~poe & fs & ee, ev & ~poe & fs & ee)
        @(posedge clk);
        #1;
        `CHK(rd, h ? {24'h0, e[39:32]} : e[31:0])
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        void'($urandom(37024));
        for (int j = 0; j < 8; j++)
        begin
            m[0][j] = 40'hFF_FFFF_FFFF; m[1][j] = 40'h0; m[2][j] = 40'h0;
        end
        drv = 40'h0; olv = 40'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk;
        for (int i = 0; i < 400; i++)
        begin
            if (i % 8 == 0)
            begin
                @(posedge clk);
                fn[10*($urandom % 40) +: 10] <= 10'($urandom % 3);
                ee <= 40'({$urandom, $urandom});
                ev <= 40'({$urandom, $urandom});
            end
            wr($urandom % 8, $urandom % 4, $urandom % 2, $urandom);
            chk;
        end
        // Let the board levels reach the readback before the keeper latches
        @(posedge clk);
        ee <= 40'hFF_FFFF_FFFF;
        repeat (3) @(posedge clk);
        keep <= 40'hFF_FFFF_FFFF;
        chk;
        @(posedge clk);
        ee <= 40'h0;
        repeat (5) @(posedge clk);
        #1;
        `CHK(plev & ~poe & fs, p1 & ~poe & fs)
        close_out;
    end
endmodule
`default_nettype wire
